// ---- inc/line_overhead_monitor_pkg.sv ----
// shared register map, field positions and frame counts for the line overhead monitor
package line_overhead_monitor_pkg;
  // register byte offsets
  localparam logic [7:0] ADDR_IRQ_ENABLE = 8'hE0;
  localparam logic [7:0] ADDR_IRQ_STATUS = 8'hE1;
  localparam logic [7:0] ADDR_CONFIG = 8'hE2;
  localparam logic [7:0] ADDR_SF_PERIOD_LO = 8'hE3;
  localparam logic [7:0] ADDR_SF_PERIOD_MID = 8'hE4;
  localparam logic [7:0] ADDR_SF_PERIOD_HI = 8'hE5;
  localparam logic [7:0] ADDR_SF_SAT_LO = 8'hE6;
  localparam logic [7:0] ADDR_SF_SAT_HI = 8'hE7;
  localparam logic [7:0] ADDR_SF_DECL_LO = 8'hE8;
  localparam logic [7:0] ADDR_SF_DECL_HI = 8'hE9;
  localparam logic [7:0] ADDR_SF_CLR_LO = 8'hEA;
  localparam logic [7:0] ADDR_SF_CLR_HI = 8'hEB;
  localparam logic [7:0] ADDR_SD_PERIOD_LO = 8'hEC;
  localparam logic [7:0] ADDR_SD_PERIOD_MID = 8'hED;
  localparam logic [7:0] ADDR_SD_PERIOD_HI = 8'hEE;
  localparam logic [7:0] ADDR_SD_SAT_LO = 8'hEF;
  localparam logic [7:0] ADDR_SD_SAT_HI = 8'hF0;
  localparam logic [7:0] ADDR_SD_DECL_LO = 8'hF1;
  localparam logic [7:0] ADDR_SD_DECL_HI = 8'hF2;
  localparam logic [7:0] ADDR_SD_CLR_LO = 8'hF3;
  localparam logic [7:0] ADDR_SD_CLR_HI = 8'hF4;
  localparam logic [7:0] ADDR_RX_K1 = 8'hF5;
  localparam logic [7:0] ADDR_RX_K2 = 8'hF6;
  localparam logic [7:0] ADDR_RX_SYNC = 8'hF7;
  // configuration bits
  localparam int CFG_SYNC_CAPTURE_FILTER_EN = 7;
  localparam int CFG_FAIL_MONITOR_EN = 6;
  localparam int CFG_FAIL_SATURATION_MODE = 5;
  localparam int CFG_FAIL_CLEAR_WINDOW_SEL = 4;
  localparam int CFG_DEGRADE_MONITOR_EN = 3;
  localparam int CFG_DEGRADE_SATURATION_MODE = 2;
  localparam int CFG_DEGRADE_CLEAR_WINDOW_SEL = 1;
  localparam int CFG_SYNC_BYTE_WIDTH_SEL = 0;
  localparam logic [7:0] CONFIG_RESET = 8'h00;
  // interrupt status bit positions; the enable register shares 7..3
  localparam int IRQ_PROT_BYTE_FAIL = 7;
  localparam int IRQ_APS_CHANGE = 6;
  localparam int IRQ_SYNC_STATUS = 5;
  localparam int IRQ_FAIL = 4;
  localparam int IRQ_DEGRADE = 3;
  localparam int VAL_FAIL = 2;
  localparam int VAL_DEGRADE = 1;
  localparam int VAL_PROT_BYTE_FAIL = 0;
  // window shape and frame counts
  localparam int WINDOW_SUBTOTALS = 8;
  localparam int CLEAR_WINDOW_MULT = 8;
  localparam logic [11:0] SATURATION_OFF = 12'hFFF;
  localparam logic [3:0] SYNC_STABLE_FRAMES = 4'h8;
  localparam logic [7:0] SYNC_NIBBLE_MASK = 8'h0F;
  localparam logic [1:0] APS_STABLE_FRAMES = 2'h3;
  localparam logic [1:0] K1_IDENTICAL_FRAMES = 2'h3;
  localparam logic [3:0] PROT_FAIL_FRAMES = 4'hC;
endpackage : line_overhead_monitor_pkg

// ---- logic/ber_window_monitor.sv ----
// sliding-window b2 error accumulator with declare/clear thresholds for one alarm
`timescale 1ns/1ps
module ber_window_monitor #(
  parameter int ERRW = 12,
  parameter int SUBW = 16
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic enable,
  input wire logic frame_pulse,
  input wire logic [ERRW-1:0] err_count,
  input wire logic [23:0] accum_period,
  input wire logic [11:0] sat_threshold,
  input wire logic [11:0] declare_threshold,
  input wire logic [11:0] clear_threshold,
  input wire logic sat_mode,
  input wire logic clear_window_sel,
  output logic alarm,
  output logic alarm_change
);
  localparam int DEPTH = line_overhead_monitor_pkg::WINDOW_SUBTOTALS;
  localparam int WINW = SUBW + $clog2(DEPTH);
  localparam int LONG_SUBS = DEPTH * line_overhead_monitor_pkg::CLEAR_WINDOW_MULT;
  localparam int LCW = $clog2(LONG_SUBS);
  localparam int LONGW = SUBW + LCW;

  typedef struct packed {
    logic [DEPTH-1:0][SUBW-1:0] hist;
    logic [WINW-1:0] win_sum;
    logic [SUBW-1:0] sub;
    logic [23:0] frm;
    logic [LONGW-1:0] long_sum;
    logic [LCW-1:0] long_cnt;
    logic alarm;
    logic change;
  } ber_state_t;

  ber_state_t st_r;
  ber_state_t st_nxt;
  logic sat_off;
  logic [ERRW-1:0] err_capped;
  logic [SUBW:0] sub_add;
  logic [SUBW-1:0] sub_val;
  logic [WINW-1:0] win_new;
  logic [LONGW-1:0] long_new;
  logic last_frame;

  always_comb begin
    st_nxt = st_r;
    st_nxt.change = 1'b0;
    sat_off = (sat_threshold == line_overhead_monitor_pkg::SATURATION_OFF);
    err_capped = err_count;
    if (!sat_mode && !sat_off && err_count > ERRW'(sat_threshold)) begin
      err_capped = ERRW'(sat_threshold);
    end
    sub_add = {1'b0, st_r.sub} + (SUBW+1)'(err_capped);
    sub_val = sub_add[SUBW] ? '1 : sub_add[SUBW-1:0];
    if (sat_mode && !sat_off && sub_val > SUBW'(sat_threshold)) begin
      sub_val = SUBW'(sat_threshold);
    end
    // a zero period behaves as one frame per subtotal
    last_frame = ({1'b0, st_r.frm} + 25'h0000001) >= {1'b0, accum_period};
    win_new = st_r.win_sum - WINW'(st_r.hist[DEPTH-1]) + WINW'(sub_val);
    long_new = st_r.long_sum + LONGW'(sub_val);
    if (!enable) begin
      st_nxt = '0;
    end else if (frame_pulse) begin
      if (!last_frame) begin
        st_nxt.frm = st_r.frm + 24'h000001;
        st_nxt.sub = sub_val;
      end else begin
        st_nxt.frm = '0;
        st_nxt.sub = '0;
        st_nxt.hist = {st_r.hist[DEPTH-2:0], sub_val};
        st_nxt.win_sum = win_new;
        if (!st_r.alarm) begin
          st_nxt.long_sum = '0;
          st_nxt.long_cnt = '0;
          if (win_new >= WINW'(declare_threshold)) begin
            st_nxt.alarm = 1'b1;
            st_nxt.change = 1'b1;
          end
        end else if (!clear_window_sel) begin
          if (win_new < WINW'(clear_threshold)) begin
            st_nxt.alarm = 1'b0;
            st_nxt.change = 1'b1;
          end
        end else begin
          // long clearing window is evaluated in blocks of eight declaration windows
          st_nxt.long_sum = long_new;
          st_nxt.long_cnt = st_r.long_cnt + LCW'(1);
          if (st_r.long_cnt == LCW'(LONG_SUBS - 1)) begin
            st_nxt.long_sum = '0;
            st_nxt.long_cnt = '0;
            if (long_new < LONGW'(clear_threshold)) begin
              st_nxt.alarm = 1'b0;
              st_nxt.change = 1'b1;
            end
          end
        end
      end
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign alarm = st_r.alarm;
  assign alarm_change = st_r.change;
endmodule : ber_window_monitor

// ---- logic/line_overhead_monitor.sv ----
// receive line overhead monitor: ber alarms, sync status filter, aps capture, register port
//
// Strobed register access is this design's own decision.
`timescale 1ns/1ps
module line_overhead_monitor #(
  parameter int ERRW = 12
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic [7:0] addr,
  input wire logic [7:0] wr_data,
  input wire logic wr_en,
  input wire logic rd_en,
  output logic [7:0] rd_data,
  input wire logic frame_pulse,
  input wire logic [ERRW-1:0] b2_err_count,
  input wire logic [7:0] k1_in,
  input wire logic [7:0] k2_in,
  input wire logic [7:0] s1_in,
  output logic irq,
  output logic fail_alarm,
  output logic degrade_alarm,
  output logic protection_byte_failure
);
  typedef struct packed {
    logic [7:0] config_r;
    logic [4:0] irq_enable;
    logic [4:0] irq_flags;
    logic [23:0] fail_period;
    logic [11:0] fail_sat;
    logic [11:0] fail_decl;
    logic [11:0] fail_clr;
    logic [23:0] degr_period;
    logic [11:0] degr_sat;
    logic [11:0] degr_decl;
    logic [11:0] degr_clr;
    logic [7:0] rdata;
    logic irq;
    logic [7:0] k1;
    logic [7:0] k2;
    logic [15:0] aps_cand;
    logic [1:0] aps_cnt;
    logic [7:0] k1_prev;
    logic [1:0] k1_run;
    logic [3:0] bad_frames;
    logic prot_fail;
    logic [7:0] sync;
    logic [7:0] sync_cand;
    logic [3:0] sync_cnt;
  } mon_state_t;

  mon_state_t st_r;
  mon_state_t st_nxt;
  logic fail_change;
  logic degr_change;
  logic [7:0] sync_mask;
  logic [7:0] read_val;
  logic [4:0] flag_set;
  logic sync_load;
  logic aps_load;
  logic prot_change;
  logic [1:0] run_nxt;
  logic [1:0] aps_cnt_nxt;
  logic [3:0] sync_cnt_nxt;

  // fail and degrade windows share one evaluator design
  ber_window_monitor #(
    .ERRW(ERRW)
  ) fail_mon (
    .clk(clk),
    .reset(reset),
    .enable(st_r.config_r[line_overhead_monitor_pkg::CFG_FAIL_MONITOR_EN]),
    .frame_pulse(frame_pulse),
    .err_count(b2_err_count),
    .accum_period(st_r.fail_period),
    .sat_threshold(st_r.fail_sat),
    .declare_threshold(st_r.fail_decl),
    .clear_threshold(st_r.fail_clr),
    .sat_mode(st_r.config_r[line_overhead_monitor_pkg::CFG_FAIL_SATURATION_MODE]),
    .clear_window_sel(st_r.config_r[line_overhead_monitor_pkg::CFG_FAIL_CLEAR_WINDOW_SEL]),
    .alarm(fail_alarm),
    .alarm_change(fail_change)
  );

  ber_window_monitor #(
    .ERRW(ERRW)
  ) degrade_mon (
    .clk(clk),
    .reset(reset),
    .enable(st_r.config_r[line_overhead_monitor_pkg::CFG_DEGRADE_MONITOR_EN]),
    .frame_pulse(frame_pulse),
    .err_count(b2_err_count),
    .accum_period(st_r.degr_period),
    .sat_threshold(st_r.degr_sat),
    .declare_threshold(st_r.degr_decl),
    .clear_threshold(st_r.degr_clr),
    .sat_mode(st_r.config_r[line_overhead_monitor_pkg::CFG_DEGRADE_SATURATION_MODE]),
    .clear_window_sel(st_r.config_r[line_overhead_monitor_pkg::CFG_DEGRADE_CLEAR_WINDOW_SEL]),
    .alarm(degrade_alarm),
    .alarm_change(degr_change)
  );

  always_comb begin
    st_nxt = st_r;
    sync_load = 1'b0;
    aps_load = 1'b0;
    prot_change = 1'b0;
    run_nxt = st_r.k1_run;
    aps_cnt_nxt = st_r.aps_cnt;
    sync_cnt_nxt = st_r.sync_cnt;
    sync_mask = st_r.config_r[line_overhead_monitor_pkg::CFG_SYNC_BYTE_WIDTH_SEL] ? 8'hFF :
                line_overhead_monitor_pkg::SYNC_NIBBLE_MASK;

    // overhead byte processing, once per frame
    if (frame_pulse) begin
      // aps code must persist for three frames before it is captured
      if ({k1_in, k2_in} == st_r.aps_cand) begin
        if (st_r.aps_cnt != line_overhead_monitor_pkg::APS_STABLE_FRAMES) begin
          aps_cnt_nxt = st_r.aps_cnt + 2'h1;
        end
      end else begin
        aps_cnt_nxt = 2'h1;
      end
      st_nxt.aps_cand = {k1_in, k2_in};
      st_nxt.aps_cnt = aps_cnt_nxt;
      if (aps_cnt_nxt == line_overhead_monitor_pkg::APS_STABLE_FRAMES &&
          {k1_in, k2_in} != {st_r.k1, st_r.k2}) begin
        st_nxt.k1 = k1_in;
        st_nxt.k2 = k2_in;
        aps_load = 1'b1;
      end

      // byte failure watches for runs of identical k1
      if (k1_in == st_r.k1_prev && st_r.k1_run != 2'h0) begin
        if (st_r.k1_run != line_overhead_monitor_pkg::K1_IDENTICAL_FRAMES) begin
          run_nxt = st_r.k1_run + 2'h1;
        end
      end else begin
        run_nxt = 2'h1;
      end
      st_nxt.k1_prev = k1_in;
      st_nxt.k1_run = run_nxt;
      if (run_nxt == line_overhead_monitor_pkg::K1_IDENTICAL_FRAMES) begin
        st_nxt.bad_frames = 4'h0;
        if (st_r.prot_fail) begin
          st_nxt.prot_fail = 1'b0;
          prot_change = 1'b1;
        end
      end else if (st_r.bad_frames != line_overhead_monitor_pkg::PROT_FAIL_FRAMES) begin
        // the count stops at the limit so it cannot wrap and drop the alarm
        st_nxt.bad_frames = st_r.bad_frames + 4'h1;
        if (st_r.bad_frames + 4'h1 == line_overhead_monitor_pkg::PROT_FAIL_FRAMES &&
            !st_r.prot_fail) begin
          st_nxt.prot_fail = 1'b1;
          prot_change = 1'b1;
        end
      end

      // sync status capture
      if (st_r.config_r[line_overhead_monitor_pkg::CFG_SYNC_CAPTURE_FILTER_EN]) begin
        if ((s1_in & sync_mask) == (st_r.sync_cand & sync_mask) && st_r.sync_cnt != 4'h0) begin
          if (st_r.sync_cnt != line_overhead_monitor_pkg::SYNC_STABLE_FRAMES) begin
            sync_cnt_nxt = st_r.sync_cnt + 4'h1;
          end
        end else begin
          sync_cnt_nxt = 4'h1;
        end
        st_nxt.sync_cand = s1_in;
        st_nxt.sync_cnt = sync_cnt_nxt;
        if (sync_cnt_nxt == line_overhead_monitor_pkg::SYNC_STABLE_FRAMES &&
            (s1_in & sync_mask) != (st_r.sync & sync_mask)) begin
          st_nxt.sync = s1_in;
          sync_load = 1'b1;
        end
      end else begin
        // unfiltered: every frame is written straight through
        st_nxt.sync = s1_in;
        st_nxt.sync_cand = s1_in;
        st_nxt.sync_cnt = 4'h1;
        sync_load = (s1_in != st_r.sync);
      end
    end

    // register read, answered in the next cycle
    case (addr)
      line_overhead_monitor_pkg::ADDR_IRQ_ENABLE: begin
        read_val = {st_r.irq_enable, 3'h0};
      end
      line_overhead_monitor_pkg::ADDR_IRQ_STATUS: begin
        read_val = {st_r.irq_flags, fail_alarm, degrade_alarm, st_r.prot_fail};
      end
      line_overhead_monitor_pkg::ADDR_CONFIG: begin
        read_val = st_r.config_r;
      end
      line_overhead_monitor_pkg::ADDR_SF_PERIOD_LO: begin
        read_val = st_r.fail_period[7:0];
      end
      line_overhead_monitor_pkg::ADDR_SF_PERIOD_MID: begin
        read_val = st_r.fail_period[15:8];
      end
      line_overhead_monitor_pkg::ADDR_SF_PERIOD_HI: begin
        read_val = st_r.fail_period[23:16];
      end
      line_overhead_monitor_pkg::ADDR_SF_SAT_LO: begin
        read_val = st_r.fail_sat[7:0];
      end
      line_overhead_monitor_pkg::ADDR_SF_SAT_HI: begin
        read_val = {4'h0, st_r.fail_sat[11:8]};
      end
      line_overhead_monitor_pkg::ADDR_SF_DECL_LO: begin
        read_val = st_r.fail_decl[7:0];
      end
      line_overhead_monitor_pkg::ADDR_SF_DECL_HI: begin
        read_val = {4'h0, st_r.fail_decl[11:8]};
      end
      line_overhead_monitor_pkg::ADDR_SF_CLR_LO: begin
        read_val = st_r.fail_clr[7:0];
      end
      line_overhead_monitor_pkg::ADDR_SF_CLR_HI: begin
        read_val = {4'h0, st_r.fail_clr[11:8]};
      end
      line_overhead_monitor_pkg::ADDR_SD_PERIOD_LO: begin
        read_val = st_r.degr_period[7:0];
      end
      line_overhead_monitor_pkg::ADDR_SD_PERIOD_MID: begin
        read_val = st_r.degr_period[15:8];
      end
      line_overhead_monitor_pkg::ADDR_SD_PERIOD_HI: begin
        read_val = st_r.degr_period[23:16];
      end
      line_overhead_monitor_pkg::ADDR_SD_SAT_LO: begin
        read_val = st_r.degr_sat[7:0];
      end
      line_overhead_monitor_pkg::ADDR_SD_SAT_HI: begin
        read_val = {4'h0, st_r.degr_sat[11:8]};
      end
      line_overhead_monitor_pkg::ADDR_SD_DECL_LO: begin
        read_val = st_r.degr_decl[7:0];
      end
      line_overhead_monitor_pkg::ADDR_SD_DECL_HI: begin
        read_val = {4'h0, st_r.degr_decl[11:8]};
      end
      line_overhead_monitor_pkg::ADDR_SD_CLR_LO: begin
        read_val = st_r.degr_clr[7:0];
      end
      line_overhead_monitor_pkg::ADDR_SD_CLR_HI: begin
        read_val = {4'h0, st_r.degr_clr[11:8]};
      end
      line_overhead_monitor_pkg::ADDR_RX_K1: begin
        read_val = st_r.k1;
      end
      line_overhead_monitor_pkg::ADDR_RX_K2: begin
        read_val = st_r.k2;
      end
      line_overhead_monitor_pkg::ADDR_RX_SYNC: begin
        read_val = st_r.sync;
      end
      default: read_val = 8'h00;
    endcase
    // idle read data is zero so a stale byte is never taken for an answer
    st_nxt.rdata = rd_en ? read_val : 8'h00;

    // register write
    if (wr_en) begin
      case (addr)
        line_overhead_monitor_pkg::ADDR_IRQ_ENABLE:
          st_nxt.irq_enable = wr_data[7:3];
        line_overhead_monitor_pkg::ADDR_CONFIG:
          st_nxt.config_r = wr_data;
        // each byte lands alone; a wide value is whole only after its last byte
        line_overhead_monitor_pkg::ADDR_SF_PERIOD_LO:
          st_nxt.fail_period[7:0] = wr_data;
        line_overhead_monitor_pkg::ADDR_SF_PERIOD_MID:
          st_nxt.fail_period[15:8] = wr_data;
        line_overhead_monitor_pkg::ADDR_SF_PERIOD_HI:
          st_nxt.fail_period[23:16] = wr_data;
        line_overhead_monitor_pkg::ADDR_SF_SAT_LO:
          st_nxt.fail_sat[7:0] = wr_data;
        line_overhead_monitor_pkg::ADDR_SF_SAT_HI:
          st_nxt.fail_sat[11:8] = wr_data[3:0];
        line_overhead_monitor_pkg::ADDR_SF_DECL_LO:
          st_nxt.fail_decl[7:0] = wr_data;
        line_overhead_monitor_pkg::ADDR_SF_DECL_HI:
          st_nxt.fail_decl[11:8] = wr_data[3:0];
        line_overhead_monitor_pkg::ADDR_SF_CLR_LO:
          st_nxt.fail_clr[7:0] = wr_data;
        line_overhead_monitor_pkg::ADDR_SF_CLR_HI:
          st_nxt.fail_clr[11:8] = wr_data[3:0];
        line_overhead_monitor_pkg::ADDR_SD_PERIOD_LO:
          st_nxt.degr_period[7:0] = wr_data;
        line_overhead_monitor_pkg::ADDR_SD_PERIOD_MID:
          st_nxt.degr_period[15:8] = wr_data;
        line_overhead_monitor_pkg::ADDR_SD_PERIOD_HI:
          st_nxt.degr_period[23:16] = wr_data;
        line_overhead_monitor_pkg::ADDR_SD_SAT_LO:
          st_nxt.degr_sat[7:0] = wr_data;
        line_overhead_monitor_pkg::ADDR_SD_SAT_HI:
          st_nxt.degr_sat[11:8] = wr_data[3:0];
        line_overhead_monitor_pkg::ADDR_SD_DECL_LO:
          st_nxt.degr_decl[7:0] = wr_data;
        line_overhead_monitor_pkg::ADDR_SD_DECL_HI:
          st_nxt.degr_decl[11:8] = wr_data[3:0];
        line_overhead_monitor_pkg::ADDR_SD_CLR_LO:
          st_nxt.degr_clr[7:0] = wr_data;
        line_overhead_monitor_pkg::ADDR_SD_CLR_HI:
          st_nxt.degr_clr[11:8] = wr_data[3:0];
        default: st_nxt.config_r = st_nxt.config_r;
      endcase
    end

    // sticky flags: a read clears, but an event in the same cycle survives
    flag_set = {prot_change, aps_load, sync_load, fail_change, degr_change};
    if (rd_en && addr == line_overhead_monitor_pkg::ADDR_IRQ_STATUS) begin
      st_nxt.irq_flags = flag_set;
    end else begin
      st_nxt.irq_flags = st_r.irq_flags | flag_set;
    end
    st_nxt.irq = |(st_nxt.irq_flags & st_nxt.irq_enable);
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      st_r <= '0;
      st_r.config_r <= line_overhead_monitor_pkg::CONFIG_RESET;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign rd_data = st_r.rdata;
  assign irq = st_r.irq;
  assign protection_byte_failure = st_r.prot_fail;
endmodule : line_overhead_monitor

// ---- verif/line_overhead_monitor_assertions.sv ----
// concurrent checks on the ports of the line overhead monitor
`timescale 1ns/1ps
module line_overhead_monitor_assertions #(
  parameter int ERRW = 12
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic [7:0] addr,
  input wire logic [7:0] wr_data,
  input wire logic wr_en,
  input wire logic rd_en,
  input wire logic [7:0] rd_data,
  input wire logic frame_pulse,
  input wire logic [ERRW-1:0] b2_err_count,
  input wire logic [7:0] k1_in,
  input wire logic [7:0] k2_in,
  input wire logic [7:0] s1_in,
  input wire logic irq,
  input wire logic fail_alarm,
  input wire logic degrade_alarm,
  input wire logic protection_byte_failure
);
  // mirror of the interrupt enable bits, so irq can be tied to what software allowed
  logic [4:0] en_r;
  always_ff @(posedge clk) begin
    if (reset) en_r <= 5'h00;
    else if (wr_en && addr == 8'hE0) en_r <= wr_data[7:3];
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  chk_rd_idle: assert property (!$past(rd_en) |-> rd_data == 8'h00)
    else $error("read data not idle");
  chk_fail_rise: assert property ($rose(fail_alarm) |-> $past(frame_pulse) || $past(frame_pulse, 2))
    else $error("fail alarm rose without a frame");
  chk_deg_rise: assert property ($rose(degrade_alarm) |-> $past(frame_pulse) || $past(frame_pulse, 2))
    else $error("degrade alarm rose without a frame");
  chk_pbf_frame: assert property ($changed(protection_byte_failure) |-> $past(frame_pulse))
    else $error("byte failure moved without a frame");
  chk_pbf_irq: assert property ($changed(protection_byte_failure) && en_r[4] |-> ##[0:1] irq)
    else $error("byte failure change raised no interrupt");
  chk_irq_enabled: assert property (irq |-> (en_r | $past(en_r)) != 5'h00)
    else $error("interrupt with all sources masked");
  chk_fail_disable: assert property (wr_en && addr == 8'hE2 && !wr_data[6] |-> ##[1:2] !fail_alarm)
    else $error("fail alarm survived disable");
  chk_deg_disable: assert property (wr_en && addr == 8'hE2 && !wr_data[3] |-> ##[1:2] !degrade_alarm)
    else $error("degrade alarm survived disable");
  cov_fail: cover property ($rose(fail_alarm));
  cov_degrade: cover property ($rose(degrade_alarm));
  cov_pbf_off: cover property ($fell(protection_byte_failure));
endmodule : line_overhead_monitor_assertions

bind line_overhead_monitor line_overhead_monitor_assertions #(.ERRW(ERRW)) u_chk (.clk(clk), .reset(reset),
  .addr(addr), .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data), .frame_pulse(frame_pulse),
  .b2_err_count(b2_err_count), .k1_in(k1_in), .k2_in(k2_in), .s1_in(s1_in), .irq(irq), .fail_alarm(fail_alarm),
  .degrade_alarm(degrade_alarm), .protection_byte_failure(protection_byte_failure));

// ---- verif/frame_source.sv ----
// far-end framer model: one frame per request, then a programmable quiet gap
`timescale 1ns/1ps
module frame_source (
  input wire logic clk,
  input wire logic reset,
  input wire logic send,
  input wire logic [7:0] gap,
  input wire logic [11:0] err,
  input wire logic [7:0] k1,
  input wire logic [7:0] k2,
  input wire logic [7:0] s1,
  output logic busy,
  output logic frame_pulse,
  output logic [11:0] b2_err_count,
  output logic [7:0] k1_in,
  output logic [7:0] k2_in,
  output logic [7:0] s1_in
);
  logic [7:0] cnt_r;
  assign busy = send || cnt_r != 8'h00;
  always_ff @(posedge clk) begin
    if (reset) begin
      cnt_r <= 8'h00;
      frame_pulse <= 1'b0;
      {b2_err_count, k1_in, k2_in, s1_in} <= '0;
    end else if (send && cnt_r == 8'h00) begin
      cnt_r <= gap;
      frame_pulse <= 1'b1;
      {b2_err_count, k1_in, k2_in, s1_in} <= {err, k1, k2, s1};
    end else begin
      cnt_r <= cnt_r - {7'h00, cnt_r != 8'h00};
      frame_pulse <= 1'b0;
      // stale overhead toggles every cycle so nothing outside the pulse can match by luck
      {b2_err_count, k1_in, k2_in, s1_in} <= ~{b2_err_count, k1_in, k2_in, s1_in};
    end
  end
endmodule : frame_source

// ---- verif/line_overhead_monitor_test.sv ----
// self-checking bench: register port, framer traffic and alarm outputs
`timescale 1ns/1ps
module line_overhead_monitor_test;
  logic clk, reset, wr_en, rd_en, send, busy, frame_pulse, irq, fail_alarm, degrade_alarm, pbf, rd_d;
  logic [7:0] addr, wr_data, rd_data, k1, k2, s1, k1_in, k2_in, s1_in, gap, m;
  logic [11:0] err, b2;
  logic [15:0] lf;
  logic [7:0] expq[$], mskq[$];
  logic [7:0] cfg[9] = '{8'h01, 8'h00, 8'h00, 8'hFF, 8'h0F, 8'h05, 8'h00, 8'h05, 8'h00};
  int n_mismatch, checks_done;
  wire [7:0] st = {4'h0, irq, fail_alarm, degrade_alarm, pbf};
  line_overhead_monitor dut (.clk(clk), .reset(reset), .addr(addr), .wr_data(wr_data), .wr_en(wr_en),
    .rd_en(rd_en), .rd_data(rd_data), .frame_pulse(frame_pulse), .b2_err_count(b2), .k1_in(k1_in),
    .k2_in(k2_in), .s1_in(s1_in), .irq(irq), .fail_alarm(fail_alarm), .degrade_alarm(degrade_alarm),
    .protection_byte_failure(pbf));
  frame_source far (.clk(clk), .reset(reset), .send(send), .gap(gap), .err(err), .k1(k1), .k2(k2), .s1(s1),
    .busy(busy), .frame_pulse(frame_pulse), .b2_err_count(b2), .k1_in(k1_in), .k2_in(k2_in), .s1_in(s1_in));
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  function automatic logic [15:0] nx(logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction : nx
  task automatic chk(logic [7:0] seen, logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic wr(logic [7:0] a, logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wr_data <= d;
    wr_en <= 1'b1;
    @(posedge clk);
    wr_en <= 1'b0;
  endtask : wr
  task automatic rd(logic [7:0] a, logic [7:0] e, logic [7:0] k);
    @(posedge clk);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge clk);
    rd_en <= 1'b0;
    expq.push_back(e & k);
    mskq.push_back(k);
  endtask : rd
  // one frame through the framer; the random gap exercises prompt and slow spacing
  task automatic frm(logic [11:0] e, logic [7:0] a, logic [7:0] b, logic [7:0] c);
    int t;
    lf = nx(lf);
    @(posedge clk);
    err <= e;
    k1 <= a;
    k2 <= b;
    s1 <= c;
    gap <= {6'h00, lf[1:0]} + 8'h02;
    send <= 1'b1;
    @(posedge clk);
    send <= 1'b0;
    t = 0;
    while (busy && t < 40) begin
      @(posedge clk);
      t++;
    end
    // a framer that never goes idle counts as a mismatch
    chk({7'h00, busy}, 8'h00);
    repeat (3) @(posedge clk);
  endtask : frm
  always @(posedge clk) begin
    rd_d <= rd_en;
    if (rd_d === 1'b1) begin
      m = mskq.pop_front();
      chk(rd_data & m, expq.pop_front());
    end
  end
  task automatic results();
    $display("mismatches %0d, checks %0d", n_mismatch, checks_done);
    if (n_mismatch == 0 && checks_done > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : results
  initial begin
    #400000;
    n_mismatch++;
    results();
  end
  initial begin
    logic [7:0] b, en, al;
    {reset, wr_en, rd_en, send} = 4'b1000;
    {addr, wr_data, err, k1, k2, s1, gap} = '0;
    lf = 16'h0010;
    n_mismatch = 0;
    checks_done = 0;
    repeat (16) @(posedge clk);
    reset <= 1'b0;
    for (int a = 8'hE0; a < 8'hF8; a++) rd(a[7:0], 8'h00, 8'hFF);
    wr(8'hD0, 8'hFF);
    rd(8'hD0, 8'h00, 8'hFF);
    wr(8'hF5, 8'hAA);
    rd(8'hF5, 8'h00, 8'hFF);
    for (int a = 8'hE3; a < 8'hEA; a++) begin
      lf = nx(lf);
      wr(a[7:0], lf[7:0]);
      rd(a[7:0], (a == 8'hE7 || a == 8'hE9) ? (lf[7:0] & 8'h0F) : lf[7:0], 8'hFF);
    end
    wr(8'hE0, 8'hF8);
    // same sequence for both monitors: fail block at E3, degrade block at EC
    for (int i = 0; i < 2; i++) begin
      b = i ? 8'hEC : 8'hE3;
      en = i ? 8'h08 : 8'h40;
      al = i ? 8'h02 : 8'h04;
      foreach (cfg[j]) wr(b + j[7:0], cfg[j]);
      wr(8'hE2, en);
      frm(12'd4, 0, 0, 0);
      chk(st, 8'h00);
      frm(12'd1, 0, 0, 0);
      chk(st, al | 8'h08);
      rd(8'hE1, al | (al << 2), 8'h1F);
      rd(8'hE1, al, 8'h1F);
      repeat (6) frm(12'd0, 0, 0, 0);
      chk(st, al);
      frm(12'd0, 0, 0, 0);
      chk(st, 8'h08);
      rd(8'hE1, al << 2, 8'h1F);
      wr(8'hE2, 8'h00);
      wr(b + 8'h03, 8'h03);
      wr(b + 8'h04, 8'h00);
      wr(8'hE2, en);
      frm(12'd9, 0, 0, 0);
      chk(st, 8'h00);
      frm(12'd9, 0, 0, 0);
      chk(st, al | 8'h08);
      wr(8'hE2, 8'h00);
      repeat (2) @(posedge clk);
      chk(st, 8'h08);
      rd(8'hE1, al << 2, 8'h1F);
      rd(8'hE1, 8'h00, 8'h1F);
      wr(b, 8'h02);
      wr(8'hE2, en | (i ? 8'h04 : 8'h20));
      repeat (2) frm(12'd9, 0, 0, 0);
      chk(st, 8'h00);
      wr(8'hE2, 8'h00);
      wr(b, 8'h01);
      wr(b + 8'h03, 8'hFF);
      wr(b + 8'h04, 8'h0F);
      wr(b + 8'h07, 8'h06);
      wr(8'hE2, en | (i ? 8'h02 : 8'h10));
      frm(12'd5, 0, 0, 0);
      repeat (8) frm(12'd0, 0, 0, 0);
      chk(st & 8'h07, al);
      repeat (60) frm(12'd0, 0, 0, 0);
      chk(st & 8'h07, 8'h00);
      wr(8'hE2, 8'h00);
      rd(8'hE1, 8'h00, 8'h00);
    end
    wr(8'hE0, 8'h00);
    frm(12'd0, 0, 0, 8'h5A);
    chk(st, 8'h00);
    rd(8'hF7, 8'h5A, 8'hFF);
    rd(8'hE1, 8'h20, 8'hE0);
    wr(8'hE0, 8'hF8);
    wr(8'hE2, 8'h80);
    repeat (7) frm(12'd0, 0, 0, 8'h3B);
    rd(8'hF7, 8'h5A, 8'hFF);
    frm(12'd0, 0, 0, 8'h3B);
    chk(st, 8'h08);
    rd(8'hF7, 8'h3B, 8'hFF);
    rd(8'hE1, 8'h20, 8'hE0);
    wr(8'hE2, 8'h81);
    repeat (8) frm(12'd0, 0, 0, 8'h4B);
    rd(8'hF7, 8'h4B, 8'hFF);
    rd(8'hE1, 8'h20, 8'hE0);
    wr(8'hE2, 8'h80);
    repeat (8) frm(12'd0, 0, 0, 8'h5B);
    rd(8'hF7, 8'h4B, 8'hFF);
    repeat (2) frm(12'd0, 8'h21, 8'h43, 8'h4B);
    rd(8'hF5, 8'h00, 8'hFF);
    frm(12'd0, 8'h21, 8'h43, 8'h4B);
    rd(8'hF5, 8'h21, 8'hFF);
    rd(8'hF6, 8'h43, 8'hFF);
    rd(8'hE1, 8'h40, 8'hE0);
    for (int i = 1; i < 13; i++) begin
      frm(12'd0, i[7:0], 8'h43, 8'h4B);
      if (i == 11) chk(st & 8'h01, 8'h00);
    end
    chk(st, 8'h09);
    rd(8'hE1, 8'h81, 8'hE1);
    repeat (2) frm(12'd0, 8'h77, 8'h43, 8'h4B);
    chk(st & 8'h01, 8'h01);
    frm(12'd0, 8'h77, 8'h43, 8'h4B);
    chk(st & 8'h01, 8'h00);
    rd(8'hE1, 8'h80, 8'h81);
    results();
  end
endmodule : line_overhead_monitor_test
